// [hdl/acs_pkg.sv]
// Package for the converter sequencer: map, field layouts, states, timing counts
package acs_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_RES_HI   = 8'h00;
    localparam logic [7:0] ADDR_RES_LO   = 8'h04;
    localparam logic [7:0] ADDR_CTRL0    = 8'h08;
    localparam logic [7:0] ADDR_PINCFG   = 8'h0C;
    localparam logic [7:0] ADDR_TIMING   = 8'h10;
    localparam logic [7:0] ADDR_PORT     = 8'h14;
    localparam logic [7:0] ADDR_CMPMODE  = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;

    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // Sequencing counts in bit times or clocks
    localparam logic [4:0] CONV_TADS     = 5'h0B;
    localparam logic [4:0] WAIT_TADS     = 5'h02;
    localparam logic [4:0] INSTR_CYCLES  = 5'h04;
    localparam logic [4:0] ONE_COUNT     = 5'h01;
    localparam logic [3:0] CMP_MODE_SPECIAL = 4'hB;
    localparam logic [2:0] ACQ_NONE      = 3'h0;
    localparam logic [1:0] CLK_RC_CODE   = 2'h3;

    // Bit times of automatic acquisition, indexed by select code
    localparam logic [4:0] ACQ_TADS [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                           5'h08, 5'h0C, 5'h10, 5'h14};

    // Prescaler terminal counts, indexed by clock select code
    localparam logic [5:0] DIV_MAX [8] = '{6'h01, 6'h07, 6'h1F, 6'h00,
                                          6'h03, 6'h0F, 6'h3F, 6'h00};

    localparam int PORT_W   = 8;
    localparam int ANALOG_W = 7;
    localparam int RES_W    = 10;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_SAMPLE = 3'b001,
        ST_DELAY  = 3'b010,
        ST_ACQ    = 3'b011,
        ST_CONV   = 3'b100,
        ST_WAIT   = 3'b101
    } acs_state_e;

    typedef struct packed {
        logic [1:0] reference_select;
        logic       rsvd;
        logic [2:0] channel_select;
        logic       go;
        logic       converter_on;
    } acs_ctrl0_s;

    typedef struct packed {
        logic       result_format;
        logic       rsvd;
        logic [2:0] acq_time_select;
        logic [2:0] conv_clock_select;
    } acs_timing_s;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } acs_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } acs_axi_rsp_s;

    typedef struct packed {
        acs_state_e          state;
        acs_ctrl0_s          ctrl0;
        acs_timing_s         timing;
        logic [6:0]          pincfg;
        logic [7:0]          res_hi;
        logic [7:0]          res_lo;
        logic [3:0]          cmp_mode;
        logic                done_flag;
        logic [5:0]          presc;
        logic [4:0]          cnt;
        logic                rc_s1;
        logic                rc_s2;
        logic                rc_s3;
        logic [7:0]          port_s1;
        logic [7:0]          port_s2;
        logic                aw_full;
        logic [7:0]          aw_addr;
        logic                w_full;
        logic [7:0]          w_byte;
        logic                w_lane0;
        acs_axi_rsp_s        rsp;
        logic                sample_en;
        logic                timebase_clear;
    } acs_regs_s;

endpackage

// [hdl/acs_sequencer.sv]
// Conversion sequencer for a 10-bit successive-approximation converter
//
// Summary of operation
// - Clock select code picks bit-time divider, or the RC clock when its low bits are 11
// - Zero acquisition select delays start four cycles
// - Select 010 samples four bit times first
// - Clearing go aborts; result stays unchanged
// - Two bit-time wait, then resume sampling
// - Compare trigger sets go, clears timebase
// - Converter off: trigger ignored, timebase still cleared
// - Analog-configured port pins read as zero
// - Sampling ignores pin direction bits
// - Control register fields and zero reset
// - Completion loads result, clears go, flags done
// - Conversion lasts eleven bit times
// - Zero select: go stops sampling immediately
// - Reset turns converter off, aborts conversion
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire acs_axi_req_s       axi_req,
    output var  acs_axi_rsp_s       axi_rsp,
    input  wire logic               special_event_trig,
    input  wire logic               rc_clock_in,
    input  wire logic [RES_W-1:0]   conv_result,
    input  wire logic [PORT_W-1:0]  port_pins,
    output logic                    sample_enable,
    output logic [2:0]              channel_select,
    output logic [1:0]              reference_select,
    output logic                    timebase_clear
);

    acs_regs_s              s_reg;
    acs_regs_s              s_next;
    logic                   tad_tick;
    logic                   rc_mode;
    logic                   special;
    logic [PORT_W-1:0]      port_view;
    logic [31:0]            rd_data;
    logic                   rd_hit;
    logic                   wr_hit;

    assign axi_rsp          = s_reg.rsp;
    assign sample_enable    = s_reg.sample_en;
    assign channel_select   = s_reg.ctrl0.channel_select;
    assign reference_select = s_reg.ctrl0.reference_select;
    assign timebase_clear   = s_reg.timebase_clear;

    // Bit-time tick from prescaler or synchronised RC clock edge
    assign rc_mode  = (s_reg.timing.conv_clock_select[1:0] == CLK_RC_CODE);
    assign tad_tick = rc_mode ? (s_reg.rc_s2 & ~s_reg.rc_s3)
                              : (s_reg.presc == DIV_MAX[s_reg.timing.conv_clock_select]);
    assign special  = special_event_trig & (s_reg.cmp_mode == CMP_MODE_SPECIAL);

    // Port read view, analog pins masked
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_port
            if (gi < ANALOG_W) begin : g_an
                assign port_view[gi] = s_reg.pincfg[gi] & s_reg.port_s2[gi];
            end else begin : g_dig
                assign port_view[gi] = s_reg.port_s2[gi];
            end
        end
    endgenerate

    // Read decode
    always_comb begin
        rd_hit  = 1'b1;
        rd_data = '0;
        unique case (axi_req.araddr)
            ADDR_RES_HI:  rd_data = {24'h000000, s_reg.res_hi};
            ADDR_RES_LO:  rd_data = {24'h000000, s_reg.res_lo};
            ADDR_CTRL0:   rd_data = {24'h000000, s_reg.ctrl0};
            ADDR_PINCFG:  rd_data = {25'h0000000, s_reg.pincfg};
            ADDR_TIMING:  rd_data = {24'h000000, s_reg.timing};
            ADDR_PORT:    rd_data = {24'h000000, port_view};
            ADDR_CMPMODE: rd_data = {28'h0000000, s_reg.cmp_mode};
            ADDR_STATUS:  rd_data = {31'h00000000, s_reg.done_flag};
            default:      rd_hit  = 1'b0;
        endcase
    end

    always_comb begin
        acs_ctrl0_s  wc;
        logic        do_write;
        logic        abort;
        wc       = acs_ctrl0_s'(s_reg.w_byte);
        do_write = s_reg.aw_full & s_reg.w_full & ~s_reg.rsp.bvalid;
        abort    = 1'b0;
        wr_hit   = 1'b1;
        s_next   = s_reg;

        // Synchronisers
        s_next.rc_s1   = rc_clock_in;
        s_next.rc_s2   = s_reg.rc_s1;
        s_next.rc_s3   = s_reg.rc_s2;
        s_next.port_s1 = port_pins;
        s_next.port_s2 = s_reg.port_s1;

        // Write address and data channels, taken in either order
        if (s_reg.rsp.awready & axi_req.awvalid) begin
            s_next.aw_full = 1'b1;
            s_next.aw_addr = axi_req.awaddr;
        end
        if (s_reg.rsp.wready & axi_req.wvalid) begin
            s_next.w_full  = 1'b1;
            s_next.w_byte  = axi_req.wdata[7:0];
            s_next.w_lane0 = axi_req.wstrb[0];
        end
        if (s_reg.rsp.bvalid & axi_req.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end

        if (do_write) begin
            s_next.aw_full    = 1'b0;
            s_next.w_full     = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            unique case (s_reg.aw_addr)
                ADDR_RES_HI: begin
                    if (s_reg.w_lane0) begin
                        s_next.res_hi = s_reg.w_byte;
                    end
                end
                ADDR_RES_LO: begin
                    if (s_reg.w_lane0) begin
                        s_next.res_lo = s_reg.w_byte;
                    end
                end
                ADDR_CTRL0: begin
                    if (s_reg.w_lane0) begin
                        wc.rsvd = 1'b0;
                        // Go only accepted once converter already on
                        wc.go = wc.go & s_reg.ctrl0.converter_on & wc.converter_on;
                        abort = s_reg.ctrl0.go & ~wc.go;
                        s_next.ctrl0 = wc;
                    end
                end
                ADDR_PINCFG: begin
                    if (s_reg.w_lane0) begin
                        s_next.pincfg = s_reg.w_byte[6:0];
                    end
                end
                ADDR_TIMING: begin
                    if (s_reg.w_lane0) begin
                        s_next.timing      = acs_timing_s'(s_reg.w_byte);
                        s_next.timing.rsvd = 1'b0;
                    end
                end
                ADDR_CMPMODE: begin
                    if (s_reg.w_lane0) begin
                        s_next.cmp_mode = s_reg.w_byte[3:0];
                    end
                end
                ADDR_STATUS: begin
                    if (s_reg.w_lane0 & s_reg.w_byte[0]) begin
                        s_next.done_flag = 1'b0;
                    end
                end
                ADDR_PORT: begin
                end
                default: wr_hit = 1'b0;
            endcase
            s_next.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Read channel
        if (s_reg.rsp.arready & axi_req.arvalid) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rdata  = rd_data;
            s_next.rsp.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_reg.rsp.rvalid & axi_req.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end

        // Compare trigger: clears timebase whether or not converter is on
        s_next.timebase_clear = special;
        if (special & s_reg.ctrl0.converter_on) begin
            s_next.ctrl0.go = 1'b1;
        end

        // Bit-time prescaler runs only while timing phases
        if (s_reg.state == ST_ACQ || s_reg.state == ST_CONV || s_reg.state == ST_WAIT) begin
            s_next.presc = tad_tick ? 6'h00 : s_reg.presc + 6'h01;
        end else begin
            s_next.presc = 6'h00;
        end

        unique case (s_reg.state)
            ST_OFF: begin
                if (s_reg.ctrl0.converter_on) begin
                    s_next.state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (s_reg.ctrl0.go && !abort) begin
                    if (s_reg.timing.acq_time_select == ACQ_NONE) begin
                        s_next.state = ST_DELAY;
                        s_next.cnt   = INSTR_CYCLES - ONE_COUNT;
                    end else begin
                        s_next.state = ST_ACQ;
                        s_next.cnt   = ACQ_TADS[s_reg.timing.acq_time_select] - ONE_COUNT;
                    end
                end
            end
            ST_DELAY: begin
                s_next.cnt = s_reg.cnt - ONE_COUNT;
                if (s_reg.cnt == '0) begin
                    s_next.state = ST_CONV;
                    s_next.cnt   = CONV_TADS - ONE_COUNT;
                end
            end
            ST_ACQ: begin
                if (tad_tick) begin
                    s_next.cnt = s_reg.cnt - ONE_COUNT;
                    if (s_reg.cnt == '0) begin
                        s_next.state = ST_CONV;
                        s_next.cnt   = CONV_TADS - ONE_COUNT;
                    end
                end
            end
            ST_CONV: begin
                if (tad_tick) begin
                    s_next.cnt = s_reg.cnt - ONE_COUNT;
                    if (s_reg.cnt == '0) begin
                        s_next.state     = ST_WAIT;
                        s_next.cnt       = WAIT_TADS - ONE_COUNT;
                        s_next.ctrl0.go  = 1'b0;
                        s_next.done_flag = 1'b1;
                        if (s_reg.timing.result_format) begin
                            s_next.res_hi = conv_result[9:2];
                            s_next.res_lo = {conv_result[1:0], 6'h00};
                        end else begin
                            s_next.res_hi = {6'h00, conv_result[9:8]};
                            s_next.res_lo = conv_result[7:0];
                        end
                    end
                end
            end
            ST_WAIT: begin
                if (tad_tick) begin
                    s_next.cnt = s_reg.cnt - ONE_COUNT;
                    if (s_reg.cnt == '0) begin
                        s_next.state = ST_SAMPLE;
                    end
                end
            end
            default: s_next.state = ST_OFF;
        endcase

        // Abort: no result load, straight into the wait
        if (abort && (s_reg.state == ST_DELAY || s_reg.state == ST_ACQ
                      || s_reg.state == ST_CONV)) begin
            s_next.state = ST_WAIT;
            s_next.cnt   = WAIT_TADS - ONE_COUNT;
            s_next.presc = 6'h00;
        end
        if (!s_next.ctrl0.converter_on) begin
            s_next.state    = ST_OFF;
            s_next.ctrl0.go = 1'b0;
        end

        // Sampling follows state only, never pin direction
        s_next.sample_en = (s_next.state == ST_SAMPLE) || (s_next.state == ST_ACQ);
        s_next.rsp.awready = ~s_next.aw_full & ~s_next.rsp.bvalid;
        s_next.rsp.wready  = ~s_next.w_full & ~s_next.rsp.bvalid;
        s_next.rsp.arready = ~s_next.rsp.rvalid;
    end

    // Synchronous reset clears everything, converter off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Helper: bit-time ticks seen in the current state, latched on exit
    logic [4:0] h_ticks;
    logic [4:0] h_exit;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h_ticks <= '0;
            h_exit  <= '0;
        end else begin
            h_ticks <= (s_next.state != s_reg.state) ? 5'h00 : h_ticks + 5'(tad_tick);
            if (s_next.state != s_reg.state) begin
                h_exit <= h_ticks + 5'(tad_tick);
            end
        end
    end

    sequence s_delay_run;
        (s_reg.state == ST_DELAY) [*4] ##1 (s_reg.state == ST_CONV);
    endsequence

    a_go_delay_start: assert property (@(posedge aclk) disable iff (!aresetn || !s_reg.ctrl0.go)
        (s_reg.state == ST_SAMPLE && s_reg.ctrl0.go && s_reg.timing.acq_time_select == ACQ_NONE)
        |=> s_delay_run)
        else $error("zero acquisition start not delayed four clocks");

    a_acq_four_tads: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_reg.state) == ST_ACQ && s_reg.state == ST_CONV
         && s_reg.timing.acq_time_select == 3'h2) |-> h_exit == 5'h04)
        else $error("acquisition did not last four bit times");

    a_conv_eleven: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_reg.done_flag) |-> h_exit == 5'h0B)
        else $error("conversion did not last eleven bit times");

    a_done_clears_go: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_reg.done_flag) |-> $past(s_reg.state) == ST_CONV && !s_reg.ctrl0.go
            && s_reg.state == ST_WAIT)
        else $error("completion did not clear go and enter wait");

    a_abort_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_reg.state) == ST_CONV && s_reg.state == ST_WAIT
         && !($past(tad_tick) && $past(s_reg.cnt) == 5'h00))
        |-> $stable(s_reg.res_hi) && $stable(s_reg.res_lo))
        else $error("abort changed the result registers");

    a_wait_two: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_reg.state) == ST_WAIT && s_reg.state == ST_SAMPLE) |-> h_exit == 5'h02)
        else $error("post-conversion wait not two bit times");

    a_trig_start: assert property (@(posedge aclk) disable iff (!aresetn)
        (special && s_reg.state == ST_SAMPLE && s_next.ctrl0.converter_on)
        |=> s_reg.timebase_clear && s_reg.ctrl0.go ##1 s_reg.state != ST_SAMPLE)
        else $error("trigger did not start a conversion");

    a_trig_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        (special && !s_reg.ctrl0.converter_on) |=> s_reg.timebase_clear && !s_reg.ctrl0.go)
        else $error("trigger with converter off misbehaved");

    a_analog_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_reg.rsp.arready && axi_req.arvalid && axi_req.araddr == ADDR_PORT && !s_reg.pincfg[0])
        |=> !s_reg.rsp.rdata[0])
        else $error("analog pin read as nonzero");

endmodule

`default_nettype wire

// [dv/tb_acs_sequencer.sv]
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_acs_sequencer;
    import acs_pkg::*;

    localparam logic [7:0] RST_A [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
    localparam logic [2:0] CODES [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    localparam int         DIVS  [8] = '{2, 4, 8, 16, 32, 64, 6, 6};

    logic         aclk;
    logic         aresetn;
    acs_axi_req_s req;
    acs_axi_rsp_s rsp;
    logic         trig;
    logic         rc_clk = 1'h0;
    logic [9:0]   conv_res;
    logic [7:0]   pins;
    logic         se;
    logic         se_d;
    logic [2:0]   chan;
    logic [1:0]   refsel;
    logic         tbc;
    logic [15:0]  seed;
    logic [31:0]  rdat;
    logic [1:0]   rr;
    int           err_total = 0;
    int           n_checks = 0;
    int           lo_cnt = 0;
    int           last_span = 0;
    int           rc_cnt = 0;
    int           cnt;

    acs_sequencer dut_u (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .axi_req            (req),
        .axi_rsp            (rsp),
        .special_event_trig (trig),
        .rc_clock_in        (rc_clk),
        .conv_result        (conv_res),
        .port_pins          (pins),
        .sample_enable      (se),
        .channel_select     (chan),
        .reference_select   (refsel),
        .timebase_clear     (tbc)
    );

    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end

    // Length of each low stretch of sample_enable
    always @(posedge aclk) begin
        se_d <= se;
        lo_cnt <= (se === 1'h1) ? 0 : lo_cnt + 1;
        if (se === 1'h1 && se_d !== 1'h1)
            last_span <= lo_cnt;
        rc_cnt <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
        if (rc_cnt == 2)
            rc_clk <= ~rc_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [15:0] exp_res(input logic [9:0] r, input logic f);
        return f ? {r[9:2], r[1:0], 6'h00} : {6'h00, r};
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        req.awvalid <= 1'h1;
        req.awaddr <= a;
        req.wvalid <= 1'h1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (req.awvalid && rsp.awready === 1'h1) req.awvalid <= 1'h0;
            if (req.wvalid && rsp.wready === 1'h1) req.wvalid <= 1'h0;
        end while (rsp.bvalid !== 1'h1 && n < 500);
        rr = rsp.bresp;
        req.bready <= 1'h0;
        if (n >= 500) err_total++;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        req.arvalid <= 1'h1;
        req.araddr <= a;
        req.rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (req.arvalid && rsp.arready === 1'h1) req.arvalid <= 1'h0;
        end while (rsp.rvalid !== 1'h1 && n < 500);
        rdat = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'h0;
        if (n >= 500) err_total++;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, rdat, e);
        chk("rresp", rr, RESP_OKAY);
    endtask

    task automatic wait_rise();
        int n;
        n = 0;
        while (se !== 1'h0 && n < 2000) begin @(posedge aclk); n++; end
        while (se !== 1'h1 && n < 4000) begin @(posedge aclk); n++; end
        @(posedge aclk);
    endtask

    task automatic pulse(output int c);
        c = 0;
        @(posedge aclk);
        trig <= 1'h1;
        @(posedge aclk);
        trig <= 1'h0;
        repeat (4) begin
            @(posedge aclk);
            if (tbc === 1'h1) c++;
        end
    endtask

    task automatic run_conv(input logic [2:0] code, input logic [2:0] acq, input logic f,
                            input int div);
        int          ex;
        logic [15:0] er;
        seed = lfsr(seed);
        conv_res <= seed[9:0];
        er = exp_res(seed[9:0], f);
        ex = (acq == 3'h0 ? 4 : 0) + 13 * div;
        wr(ADDR_TIMING, {24'h0, f, 1'h0, acq, code}, 4'hF);
        wr(ADDR_CTRL0, 32'h01, 4'hF);
        wr(ADDR_CTRL0, 32'h03, 4'hF);
        wait_rise();
        chk("span", last_span > ex - div && last_span <= ex + 4, 1'h1);
        rdchk(ADDR_RES_HI, {24'h0, er[15:8]}, "res_hi");
        rdchk(ADDR_RES_LO, {24'h0, er[7:0]}, "res_lo");
        rdchk(ADDR_CTRL0, 32'h01, "go_clr");
        rdchk(ADDR_STATUS, 32'h01, "done");
        wr(ADDR_STATUS, 32'h01, 4'hF);
        rdchk(ADDR_STATUS, 32'h00, "done_clr");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        aresetn = 1'h0;
        req = '0;
        trig = 1'h0;
        conv_res = 10'h000;
        pins = 8'h00;
        seed = 16'h2E61;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        foreach (RST_A[i]) rdchk(RST_A[i], 32'h0, "reset");
        chk("sel_rst", {refsel, chan}, 5'h00);
        repeat (4) begin
            seed = lfsr(seed);
            wr(ADDR_TIMING, {24'h0, seed[7:0]}, 4'hF);
            rdchk(ADDR_TIMING, {24'h0, seed[7:0] & 8'hBF}, "timing");
            wr(ADDR_CTRL0, {24'h0, seed[15:8] & 8'hFC}, 4'hF);
            rdchk(ADDR_CTRL0, {24'h0, seed[15:8] & 8'hDC}, "ctrl0");
            chk("fields", {refsel, chan}, {seed[15:14], seed[12:10]});
            pins <= seed[7:0];
            wr(ADDR_PINCFG, {24'h0, seed[15:8]}, 4'hF);
            rdchk(ADDR_PINCFG, {24'h0, seed[15:8] & 8'h7F}, "pincfg");
            wr(ADDR_PORT, 32'hFF, 4'hF);
            rdchk(ADDR_PORT, {24'h0, seed[7:0] & {1'h1, seed[14:8]}}, "port");
        end
        wr(ADDR_TIMING, 32'hFF, 4'h0);
        rdchk(ADDR_TIMING, {24'h0, seed[7:0] & 8'hBF}, "strobe");
        wr(8'h20, 32'h5A, 4'hF);
        chk("wr_err", rr, RESP_SLVERR);
        rd(8'h24);
        chk("rd_err", rr, RESP_SLVERR);
        chk("rd_err_d", rdat, 32'h0);
        wr(ADDR_CTRL0, 32'h00, 4'hF);
        wr(ADDR_CTRL0, 32'h03, 4'hF);
        rdchk(ADDR_CTRL0, 32'h01, "go_drop");
        for (int i = 0; i < 8; i++) run_conv(CODES[i], i == 0 ? 3'h2 : 3'h0, i[0], DIVS[i]);
        wr(ADDR_RES_HI, 32'hA5, 4'hF);
        wr(ADDR_RES_LO, 32'h5A, 4'hF);
        wr(ADDR_TIMING, 32'h06, 4'hF);
        wr(ADDR_CTRL0, 32'h03, 4'hF);
        repeat (60) @(posedge aclk);
        wr(ADDR_CTRL0, 32'h01, 4'hF);
        wait_rise();
        chk("abort", last_span > 128 && last_span < 300, 1'h1);
        rdchk(ADDR_RES_HI, 32'hA5, "keep_hi");
        rdchk(ADDR_RES_LO, 32'h5A, "keep_lo");
        rdchk(ADDR_STATUS, 32'h00, "no_done");
        wr(ADDR_CMPMODE, 32'h0B, 4'hF);
        pulse(cnt);
        chk("tb_on", cnt, 1);
        rdchk(ADDR_CTRL0, 32'h03, "trig_go");
        wr(ADDR_CTRL0, 32'h01, 4'hF);
        wait_rise();
        wr(ADDR_CTRL0, 32'h00, 4'hF);
        pulse(cnt);
        chk("tb_off", cnt, 1);
        rdchk(ADDR_CTRL0, 32'h00, "trig_off");
        chk("se_off", se, 1'h0);
        wr(ADDR_CMPMODE, 32'h00, 4'hF);
        wr(ADDR_CTRL0, 32'h01, 4'hF);
        pulse(cnt);
        chk("tb_mode", cnt, 0);
        rdchk(ADDR_CTRL0, 32'h01, "mode_go");
        wr(ADDR_CTRL0, 32'h1D, 4'hF);
        wr(ADDR_CTRL0, 32'h1F, 4'hF);
        repeat (50) @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        chk("rst_out", {se, chan, refsel}, 6'h00);
        rdchk(ADDR_CTRL0, 32'h00, "rst_c0");
        rdchk(ADDR_TIMING, 32'h00, "rst_tim");
        final_report();
    end

    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        final_report();
    end
endmodule

`default_nettype wire
